// ===== logic/alarm_pkg.sv
// Purpose: shared constants and types of the relock / pre-arm alarm controller
// Assumes: one 125 MHz system clock
// Notes: register offsets are byte addresses on the plain register port
package alarm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned HAZ_PHASE_MS = 500; // hazard on and off phase, ms
   localparam int unsigned HAZ_PHASE_TICKS = CLK_HZ / 1000 * HAZ_PHASE_MS;
   localparam int unsigned HAZ_PHASES = 4; // on, off, on, off
   localparam int unsigned RELOCK_TICKS_DEF = 1_250_000_000; // relock timer b length
   localparam int unsigned DOOR_COUNT = 4;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0c;
   localparam int unsigned CTRL_SMART_BIT = 0; // smart_key_variant when 1
   localparam int unsigned CTRL_MECH_BIT = 1; // mechanical key option enable
   localparam int unsigned CTRL_FORCE_BIT = 2; // write 1: load state field
   localparam int unsigned CTRL_STATE_LSB = 4;
   localparam int unsigned STATE_CODE_LSB = 0;
   localparam int unsigned STATE_PEND_BIT = 3;
   localparam int unsigned STATE_HOOD_BIT = 4;
   localparam int unsigned STATE_TRUNK_BIT = 5;
   localparam int unsigned STATE_HORN_BIT = 6;
   localparam int unsigned STATE_INHIBIT_BIT = 7;
   localparam int unsigned STATE_HAZARD_BIT = 8;

   ////////////////////////////////////////////////////////////////////////
   // interrupt events
   localparam int unsigned EV_AUTOLOCK = 0;
   localparam int unsigned EV_RELOCK = 1;
   localparam int unsigned EV_PREARM = 2;
   localparam int unsigned EV_RESTART = 3;
   localparam int unsigned NUM_EV = 4;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      ST_UNGUARDED = 3'b000,
      ST_ALARM = 3'b001,
      ST_PREARM = 3'b010,
      ST_ARMHOLD = 3'b011,
      ST_RELOCK_B = 3'b100,
      ST_OTHER = 3'b101
   } alarm_state_e;

   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_LOCK = 2'b01,
      CMD_UNLOCK = 2'b10
   } remote_cmd_e;

endpackage : alarm_pkg

// ===== logic/pulse_if.sv
// Purpose: link between the controller and its hazard double-pulse unit
// Assumes: both ends on the system clock
// Notes: start and abort are one-cycle pulses
interface pulse_if;
   logic start;
   logic abort;
   logic lamp;
   logic busy;
   modport ctl (output start, output abort, input lamp, input busy);
   modport unit (input start, input abort, output lamp, output busy);
endinterface : pulse_if

// ===== logic/hazard_pulser.sv
// Purpose: drives the hazard lamp twice, on and off for one phase each
// Assumes: phase length given in clock cycles
// Notes: a new start restarts the pattern, abort ends it at once
module hazard_pulser
   import alarm_pkg::*;
#(
   parameter int unsigned PHASE_TICKS = HAZ_PHASE_TICKS
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   pulse_if.unit pif
);

   typedef struct packed {
      logic [2:0] phase; // 0 idle, 1..4 active
      logic [31:0] cnt;
      logic lamp;
   } pulser_s;

   pulser_s q, d;

   ////////////////////////////////////////////////////////////////////////
   // phase divider and sequencer
   always_comb begin
      d = q;
      if (pif.abort) begin
         d = '0;
      end else if (pif.start) begin
         d.phase = 3'h1;
         d.cnt = 32'(PHASE_TICKS - 1);
         d.lamp = 1'b1;
      end else if (q.phase != 3'h0) begin
         if (q.cnt == 32'h0) begin
            d.phase = (q.phase == 3'(HAZ_PHASES)) ? 3'h0 : q.phase + 3'h1;
            d.cnt = 32'(PHASE_TICKS - 1);
            d.lamp = (d.phase == 3'h1) || (d.phase == 3'h3); // lamp on in odd phases
         end else begin
            d.cnt = q.cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pif.lamp = q.lamp;
   assign pif.busy = (q.phase != 3'h0);

   chk_start_lights: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pif.start && !pif.abort |=> pif.lamp && pif.busy) else $error("pulser did not start");

endmodule : hazard_pulser

// ===== logic/alarm_relock_prearm_fsm.sv
// Purpose: relock timer b state and entries into the pre-armed state
// Assumes: all inputs synchronous to clk_i; other alarm states set by software
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// The register addresses and the strobed register port are this design's own decisions.
module alarm_relock_prearm_fsm
   import alarm_pkg::*;
#(
   parameter int unsigned RELOCK_TICKS = RELOCK_TICKS_DEF,
   parameter int unsigned HAZ_TICKS = HAZ_PHASE_TICKS,
   parameter int unsigned DOORS = DOOR_COUNT
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   // requests
   input wire logic fob_lock_i,
   input wire logic fob_unlock_i,
   input wire logic [1:0] remote_entry_command_i,
   input wire logic prox_lock_i,
   input wire logic prox_unlock_i,
   input wire logic mech_lock_i,
   // vehicle status
   input wire logic lock_confirmed_i,
   input wire logic key_removed_i,
   input wire logic [DOORS-1:0] door_open_i,
   input wire logic hood_open_i,
   input wire logic trunk_open_i,
   // relays and status
   output logic hazard_relay_o,
   output logic horn_relay_o,
   output logic start_inhibit_o,
   output logic autolock_o,
   output logic hood_memo_o,
   output logic trunk_memo_o,
   output logic [2:0] state_o
);

   typedef struct packed {
      alarm_state_e state;
      logic [31:0] timer; // relock timer b, 0 when idle
      logic pend; // lock seen, waiting for confirmation
      logic doors_any; // door open status one cycle ago
      logic hood_memo;
      logic trunk_memo;
      logic horn;
      logic inhibit;
      logic flash; // alarm flashing of the hazard relay
      logic hazard;
      logic autolock;
      logic start;
      logic abort;
      logic smart;
      logic mech;
      logic [NUM_EV-1:0] status;
      logic [NUM_EV-1:0] mask;
      logic [31:0] rdata;
      logic irq;
   } core_s;

   core_s q, d;
   pulse_if pif ();

   logic unlock_req;
   logic lock_req;
   logic locked_ok;
   logic any_door;
   logic hood_trunk;
   logic timer_done;
   logic go_r3;
   logic go_r4;
   logic go_r5;
   logic go_r9;
   logic go_r10;
   logic go_r11;
   logic go_r12;
   logic ctrl_wr;
   logic [NUM_EV-1:0] ev;

   ////////////////////////////////////////////////////////////////////////
   // hazard double pulse unit
   hazard_pulser #(
      .PHASE_TICKS(HAZ_TICKS)
   ) u_pulser (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .pif(pif)
   );

   assign pif.start = q.start;
   assign pif.abort = q.abort;

   ////////////////////////////////////////////////////////////////////////
   // request decode
   always_comb begin
      if (q.smart) begin
         unlock_req = (remote_entry_command_i == CMD_UNLOCK) || prox_unlock_i;
         lock_req = (remote_entry_command_i == CMD_LOCK) || prox_lock_i;
      end else begin
         unlock_req = fob_unlock_i;
         lock_req = fob_lock_i;
      end
      if (q.mech && mech_lock_i) begin
         lock_req = 1'b1;
      end
   end

   // lock counts once the locks report locked
   assign locked_ok = (q.pend || lock_req) && lock_confirmed_i;
   assign any_door = |door_open_i;
   assign hood_trunk = hood_open_i || trunk_open_i;
   assign timer_done = (q.state == ST_RELOCK_B) && (q.timer == 32'h1);

   // entry conditions per source state
   assign go_r3 = (q.state == ST_UNGUARDED) && key_removed_i && hood_trunk && unlock_req;
   assign go_r4 = (q.state == ST_ALARM) && !any_door && hood_trunk && unlock_req;
   assign go_r5 = unlock_req && ((q.state == ST_ARMHOLD)
                  || ((q.state == ST_PREARM) && !any_door && hood_trunk));
   assign go_r9 = (q.state == ST_UNGUARDED) && key_removed_i && !go_r3
                  && (any_door || hood_trunk) && locked_ok;
   assign go_r10 = (q.state == ST_UNGUARDED) && key_removed_i && !go_r3 && !go_r9
                   && lock_confirmed_i && q.doors_any && !any_door && hood_trunk;
   assign go_r11 = (q.state == ST_ALARM) && !go_r4 && key_removed_i
                   && (any_door || hood_trunk) && locked_ok;
   assign go_r12 = (q.state == ST_ARMHOLD) && !unlock_req && locked_ok;

   assign ctrl_wr = we_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_FORCE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      ev = '0;
      d.start = 1'b0;
      d.abort = 1'b0;
      d.autolock = 1'b0;
      d.doors_any = any_door;
      if (lock_req) begin
         d.pend = 1'b1;
      end
      if (unlock_req) begin
         d.pend = 1'b0;
      end
      if (q.timer > 32'h0 && q.state == ST_RELOCK_B) begin
         d.timer = q.timer - 32'h1;
      end

      case (q.state)
         ST_UNGUARDED: begin
            if (go_r3) begin
               d.state = ST_RELOCK_B;
            end else if (go_r9 || go_r10) begin
               d.state = ST_PREARM;
            end
         end
         ST_ALARM: begin
            if (go_r4) begin
               d.state = ST_RELOCK_B;
               d.horn = 1'b0;
               d.inhibit = 1'b0;
               d.flash = 1'b0;
            end else if (go_r11) begin
               d.state = ST_PREARM;
               d.horn = 1'b0;
               d.inhibit = 1'b0;
               d.flash = 1'b0;
               d.abort = 1'b1;
            end
         end
         ST_PREARM: begin
            if (go_r5) begin
               d.state = ST_RELOCK_B;
            end
         end
         ST_ARMHOLD: begin
            if (go_r5) begin
               d.state = ST_RELOCK_B;
            end else if (go_r12) begin
               d.state = ST_PREARM;
            end
         end
         ST_RELOCK_B: begin
            if (unlock_req) begin
               d.timer = 32'(RELOCK_TICKS);
               d.start = 1'b1;
               ev[EV_RESTART] = 1'b1;
            end else if (locked_ok) begin
               d.state = ST_PREARM;
               d.timer = 32'h0;
            end else if (timer_done) begin
               d.autolock = 1'b1;
               d.pend = 1'b1;
               ev[EV_AUTOLOCK] = 1'b1;
            end
         end
         default: begin
            d.state = q.state;
         end
      endcase

      // common actions on every unlock entry into timer b
      if (go_r3 || go_r4 || go_r5) begin
         d.timer = 32'(RELOCK_TICKS);
         d.start = 1'b1;
         d.hood_memo = hood_open_i;
         d.trunk_memo = trunk_open_i;
         d.pend = 1'b0;
         ev[EV_RELOCK] = 1'b1;
      end
      if (d.state == ST_PREARM && q.state != ST_PREARM) begin
         d.pend = 1'b0;
         ev[EV_PREARM] = 1'b1;
      end

      // software loads states handled by other logic
      if (ctrl_wr) begin
         d.state = alarm_state_e'(wdata_i[CTRL_STATE_LSB +: 3]);
         d.pend = 1'b0;
         d.timer = 32'h0;
         if (alarm_state_e'(wdata_i[CTRL_STATE_LSB +: 3]) == ST_ALARM) begin
            d.horn = 1'b1;
            d.inhibit = 1'b1;
            d.flash = 1'b1;
         end
      end

      // hazard relay: pulse pattern or alarm flashing
      d.hazard = pif.lamp || (d.flash && d.state == ST_ALARM);

      //////////////////////////////////////////////////////////////////////
      // register writes; a new event wins over its clear
      if (we_i) begin
         case (addr_i)
            ADDR_CTRL: begin
               d.smart = wdata_i[CTRL_SMART_BIT];
               d.mech = wdata_i[CTRL_MECH_BIT];
            end
            ADDR_STATUS: begin
               d.status = q.status & ~wdata_i[NUM_EV-1:0];
            end
            ADDR_MASK: begin
               d.mask = wdata_i[NUM_EV-1:0];
            end
            default: begin
               d.mask = q.mask;
            end
         endcase
      end
      d.status = d.status | ev;
      d.irq = |(d.status & d.mask);

      // register reads, data in the next cycle only
      d.rdata = 32'h0;
      if (re_i) begin
         case (addr_i)
            ADDR_CTRL: begin
               d.rdata[CTRL_SMART_BIT] = q.smart;
               d.rdata[CTRL_MECH_BIT] = q.mech;
               d.rdata[CTRL_STATE_LSB +: 3] = q.state;
            end
            ADDR_STATUS: begin
               d.rdata[NUM_EV-1:0] = q.status;
            end
            ADDR_MASK: begin
               d.rdata[NUM_EV-1:0] = q.mask;
            end
            ADDR_STATE: begin
               d.rdata[STATE_CODE_LSB +: 3] = q.state;
               d.rdata[STATE_PEND_BIT] = q.pend;
               d.rdata[STATE_HOOD_BIT] = q.hood_memo;
               d.rdata[STATE_TRUNK_BIT] = q.trunk_memo;
               d.rdata[STATE_HORN_BIT] = q.horn;
               d.rdata[STATE_INHIBIT_BIT] = q.inhibit;
               d.rdata[STATE_HAZARD_BIT] = q.hazard;
            end
            default: begin
               d.rdata = 32'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign rdata_o = q.rdata;
   assign irq_o = q.irq;
   assign hazard_relay_o = q.hazard;
   assign horn_relay_o = q.horn;
   assign start_inhibit_o = q.inhibit;
   assign autolock_o = q.autolock;
   assign hood_memo_o = q.hood_memo;
   assign trunk_memo_o = q.trunk_memo;
   assign state_o = q.state;

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_expiry_autolock: assert property (@(posedge clk_i) disable iff (!rstn_i)
      timer_done && !unlock_req && !locked_ok && !ctrl_wr |=> autolock_o && state_o == ST_RELOCK_B)
      else $error("expiry did not autolock in place");

   chk_unlock_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
      q.state == ST_RELOCK_B && unlock_req && !ctrl_wr
      |=> q.start && q.timer == 32'(RELOCK_TICKS) && state_o == ST_RELOCK_B ##1 pif.busy)
      else $error("unlock did not restart timer b");

   chk_unguarded_entry: assert property (@(posedge clk_i) disable iff (!rstn_i)
      q.state == ST_UNGUARDED && key_removed_i && hood_trunk && unlock_req && !ctrl_wr
      |=> state_o == ST_RELOCK_B && q.start) else $error("unguarded unlock missed timer b");

   chk_alarm_relays: assert property (@(posedge clk_i) disable iff (!rstn_i)
      go_r4 && !ctrl_wr |=> state_o == ST_RELOCK_B && !horn_relay_o && !start_inhibit_o)
      else $error("alarm unlock left relays on");

   chk_prearm_unlock: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (q.state == ST_ARMHOLD || (q.state == ST_PREARM && !any_door && hood_trunk))
      && unlock_req && !ctrl_wr |=> state_o == ST_RELOCK_B)
      else $error("prearm or armhold unlock missed timer b");

   chk_memo_capture: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state_o == ST_RELOCK_B && $past(q.state) != ST_RELOCK_B && !$past(ctrl_wr)
      |-> hood_memo_o == $past(hood_open_i) && trunk_memo_o == $past(trunk_open_i))
      else $error("hood or trunk not stored");

   chk_prearm_confirm: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state_o == ST_PREARM && $past(q.state) != ST_PREARM && !$past(ctrl_wr)
      |-> $past(lock_confirmed_i)) else $error("prearm without lock confirmed");

   chk_mech_lock: assert property (@(posedge clk_i) disable iff (!rstn_i)
      q.state == ST_ARMHOLD && q.mech && mech_lock_i && lock_confirmed_i && !unlock_req
      && !ctrl_wr |=> state_o == ST_PREARM) else $error("mechanical lock ignored");

   chk_door_close: assert property (@(posedge clk_i) disable iff (!rstn_i)
      go_r10 && !ctrl_wr |=> state_o == ST_PREARM) else $error("door close lock missed");

   chk_alarm_lock: assert property (@(posedge clk_i) disable iff (!rstn_i)
      go_r11 && !ctrl_wr |=> state_o == ST_PREARM && !horn_relay_o && !start_inhibit_o
      ##1 !pif.lamp ##1 !hazard_relay_o) else $error("alarm lock left relays on");

endmodule : alarm_relock_prearm_fsm

// ===== verification/lock_model.sv
// Purpose: door lock actuators and their all-locked confirmation switch
// Assumes: lock and unlock commands sampled on clk_i
// Notes: confirmation closes DELAY cycles after a lock and opens on unlock
module lock_model #(
   parameter int unsigned DELAY = 3
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic lock_i,
   input wire logic unlock_i,
   output logic confirmed_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_q;
   // actuator travel time, then the switch reports locked
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= 0;
         confirmed_o <= 1'b0;
      end else if (unlock_i) begin
         cnt_q <= 0;
         confirmed_o <= 1'b0;
      end else if (lock_i) begin
         cnt_q <= DELAY;
      end else if (cnt_q == 1) begin
         cnt_q <= 0;
         confirmed_o <= 1'b1;
      end else if (cnt_q != 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule : lock_model

// ===== verification/tb.sv
// Purpose: self-checking bench of the relock timer b and pre-arm entries
// Assumes: short timer and hazard phase parameters
// Notes: each scenario starts from a fresh reset, except the key-in one and the two armhold lock ones
module tb
   import alarm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned RT = 40;
   localparam int unsigned HT = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic we = 1'b0, re = 1'b0, fob_lock = 1'b0, fob_unlock = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic prox_lock = 1'b0, prox_unlock = 1'b0, mech = 1'b0, manual = 1'b0;
   logic key_out = 1'b0, hood = 1'b0, trunk = 1'b0;
   logic [DOOR_COUNT-1:0] door = '0;
   logic [31:0] rdata;
   logic irq, confirmed, hazard, horn, inhibit, autolock, hood_memo, trunk_memo;
   logic [2:0] state;
   logic [31:0] d;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int t1;
   int unl[4] = '{2, 4, 2, 4};
   int lk[4] = '{3, 5, 5, 3};

   ////////////////////////////////////////////////////////////////////////
   // clock and cycle count
   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   alarm_relock_prearm_fsm #(.RELOCK_TICKS(RT), .HAZ_TICKS(HT), .DOORS(DOOR_COUNT)) i_alarm_relock_prearm_fsm (
      .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
      .rdata_o(rdata), .irq_o(irq), .fob_lock_i(fob_lock), .fob_unlock_i(fob_unlock),
      .remote_entry_command_i(cmd), .prox_lock_i(prox_lock), .prox_unlock_i(prox_unlock),
      .mech_lock_i(mech), .lock_confirmed_i(confirmed), .key_removed_i(key_out), .door_open_i(door),
      .hood_open_i(hood), .trunk_open_i(trunk), .hazard_relay_o(hazard), .horn_relay_o(horn),
      .start_inhibit_o(inhibit), .autolock_o(autolock), .hood_memo_o(hood_memo),
      .trunk_memo_o(trunk_memo), .state_o(state));

   lock_model #(.DELAY(3)) i_lock_model (
      .clk_i(clk), .rstn_i(rstn),
      .lock_i(fob_lock | mech | autolock | (cmd == 2'h1) | prox_lock | manual),
      .unlock_i(fob_unlock | (cmd == 2'h2) | prox_unlock), .confirmed_o(confirmed));

   ////////////////////////////////////////////////////////////////////////
   // helpers
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task reset;
      @(posedge clk);
      rstn <= 1'b0;
      {key_out, hood, trunk, manual} <= 4'h0;
      door <= '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
   endtask : reset

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   // one request for one cycle: fob unlock, fob lock, command unlock, command lock, prox unlock, prox lock, mech
   task req(input int k);
      @(posedge clk);
      case (k)
         0: fob_unlock <= 1'b1;
         1: fob_lock <= 1'b1;
         2: cmd <= 2'h2;
         3: cmd <= 2'h1;
         4: prox_unlock <= 1'b1;
         5: prox_lock <= 1'b1;
         default: mech <= 1'b1;
      endcase
      @(posedge clk);
      {fob_unlock, fob_lock, prox_unlock, prox_lock, mech} <= 5'h0;
      cmd <= 2'h0;
      #1;
   endtask : req

   // two hazard flashes of HT cycles on and HT off
   task haz_walk;
      int i;
      for (i = 0; i < 4 && hazard !== 1'b1; i++) step(1);
      for (i = 0; i < 4 * HT + 2; i++) begin
         chk(32'(hazard), 32'(i < HT || (i >= 2 * HT && i < 3 * HT)));
         step(1);
      end
   endtask : haz_walk

   task wait_st(input alarm_state_e s);
      int i;
      for (i = 0; i < 12 && state !== s; i++) step(1);
      chk(32'(state), 32'(s));
   endtask : wait_st

   ////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #80000;
      error_cnt++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   initial begin
      // reset values, unmapped address
      reset();
      rd(ADDR_STATE, d);
      chk(d, 32'h0);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, d);
      chk(d, 32'h0);
      rd(ADDR_CTRL, d);
      chk(d, 32'h0);
      // key in: unlock must not enter timer b
      @(posedge clk);
      trunk <= 1'b1;
      req(0);
      step(2);
      chk(32'(state), 32'(ST_UNGUARDED));
      // unguarded entry, restart, expiry, confirmed lock, interrupt
      reset();
      key_out <= 1'b1;
      trunk <= 1'b1;
      wr(ADDR_MASK, 32'h2);
      step(1);
      chk(32'(irq), 32'h0);
      req(0);
      chk(32'(state), 32'(ST_RELOCK_B));
      chk(32'({hood_memo, trunk_memo}), 32'h1);
      step(1);
      chk(32'(irq), 32'h1);
      haz_walk();
      req(0);
      t1 = cyc;
      chk(32'(state), 32'(ST_RELOCK_B));
      haz_walk();
      while (autolock !== 1'b1 && cyc - t1 < 100) step(1);
      chk(32'(cyc - t1 >= RT - 1 && cyc - t1 <= RT + 1), 32'h1);
      step(1);
      chk(32'(autolock), 32'h0);
      chk(32'(state), 32'(ST_RELOCK_B));
      wait_st(ST_PREARM);
      rd(ADDR_STATUS, d);
      chk(d, 32'hf);
      wr(ADDR_STATUS, 32'h2);
      step(1);
      chk(32'(irq), 32'h0);
      rd(ADDR_STATE, d);
      chk(d, 32'h22);
      // smart variant decoding, lock waits for confirmation
      for (int i = 0; i < 4; i++) begin
         reset();
         key_out <= 1'b1;
         hood <= 1'b1;
         wr(ADDR_CTRL, 32'h1);
         req(unl[i]);
         chk(32'(state), 32'(ST_RELOCK_B));
         chk(32'({hood_memo, trunk_memo}), 32'h2);
         req(lk[i]);
         chk(32'(state), 32'(ST_RELOCK_B));
         wait_st(ST_PREARM);
      end
      // mechanical key counts only with the option set
      reset();
      key_out <= 1'b1;
      door <= 4'h1;
      req(6);
      step(8);
      chk(32'(state), 32'(ST_UNGUARDED));
      wr(ADDR_CTRL, 32'h2);
      req(6);
      wait_st(ST_PREARM);
      // unguarded, door open, confirmed fob lock
      reset();
      key_out <= 1'b1;
      door <= 4'h8;
      req(1);
      wait_st(ST_PREARM);
      // unguarded, locked, doors close while trunk stays open
      reset();
      key_out <= 1'b1;
      trunk <= 1'b1;
      door <= 4'h2;
      @(posedge clk);
      manual <= 1'b1;
      @(posedge clk);
      manual <= 1'b0;
      step(8);
      chk(32'(state), 32'(ST_UNGUARDED));
      @(posedge clk);
      door <= 4'h0;
      wait_st(ST_PREARM);
      // alarm, doors closed, trunk open: unlock silences horn and inhibit relays
      reset();
      key_out <= 1'b1;
      trunk <= 1'b1;
      wr(ADDR_CTRL, 32'h14);
      step(1);
      chk(32'({horn, inhibit, hazard}), 32'h7);
      req(0);
      chk(32'(state), 32'(ST_RELOCK_B));
      chk(32'({horn, inhibit, trunk_memo}), 32'h1);
      // alarm, door open: confirmed lock silences all relays
      reset();
      key_out <= 1'b1;
      door <= 4'h4;
      wr(ADDR_CTRL, 32'h14);
      step(1);
      chk(32'({horn, inhibit, hazard}), 32'h7);
      req(1);
      wait_st(ST_PREARM);
      step(2);
      chk(32'({horn, inhibit, hazard}), 32'h0);
      // prearm with hood open, then armhold with all closed
      reset();
      key_out <= 1'b1;
      hood <= 1'b1;
      wr(ADDR_CTRL, 32'h24);
      req(0);
      chk(32'(state), 32'(ST_RELOCK_B));
      chk(32'({hood_memo, trunk_memo}), 32'h2);
      @(posedge clk);
      hood <= 1'b0;
      wr(ADDR_CTRL, 32'h34);
      req(0);
      chk(32'(state), 32'(ST_RELOCK_B));
      chk(32'({hood_memo, trunk_memo}), 32'h0);
      // armhold confirmed lock
      wr(ADDR_CTRL, 32'h34);
      req(1);
      wait_st(ST_PREARM);
      // armhold with mechanical option: mechanical lock counts
      wr(ADDR_CTRL, 32'h36);
      req(6);
      wait_st(ST_PREARM);
      conclude();
   end
endmodule : tb
